// *** inc/imb_pkg.sv ***
package imb_pkg;
	// array geometry
	localparam int MEM_DEPTH = 8192;
	localparam int ADDR_W = 13;
	localparam int BYTE_W = 8;
	localparam int HI_ADDR_W = ADDR_W - BYTE_W;
	localparam int WORD_W = ADDR_W + BYTE_W;
	localparam int FIFO_DEPTH = 8;
	localparam int SYNC_STAGES = 2;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 13'h0001;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;
	// device type nibble of the target address; value is arbitrary
	localparam logic [3:0] DEV_TYPE = 4'h5;
	// target address byte layout
	localparam int TA_TYPE_HI = 7;
	localparam int TA_TYPE_LO = 4;
	localparam int TA_SEL_HI = 3;
	localparam int TA_SEL_LO = 1;
	localparam int TA_RW = 0;
	localparam int CLK_MHZ = 125;
	localparam int SCL_MAX_KHZ = 1000;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_DEV = 9'h002,
		ST_ADH = 9'h004,
		ST_ADL = 9'h008,
		ST_WR = 9'h010,
		ST_ACK = 9'h020,
		ST_RD = 9'h040,
		ST_RACK = 9'h080,
		ST_RLD = 9'h100
	} imb_state_t;
endpackage : imb_pkg

// *** inc/imb_word_if.sv ***
`timescale 1ns/1ns
interface imb_word_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : imb_word_if

// *** core/imb_fifo.sv ***
`timescale 1ns/1ns
module imb_fifo
	import imb_pkg::*;
#(
	parameter int W = 8,
	parameter int D = 8
)(
	input wire logic clk_i,
	input wire logic rst_i,
	imb_word_if.snk in_if,
	imb_word_if.src out_if
);
	localparam int PW = $clog2(D);
	// full count needs the extra bit; a narrower cast wraps D to zero
	localparam logic [PW:0] CNT_FULL = (PW+1)'(D);
	localparam logic [PW-1:0] PTR_ONE = PW'(1);
	localparam logic [PW:0] CNT_ONE_P = (PW+1)'(1);

	logic [W-1:0] store_ff [0:D-1];
	logic [PW-1:0] wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
	logic [PW:0] cnt_ff, nxt_cnt;
	logic push, pop;

	assign in_if.ready = (cnt_ff != CNT_FULL);
	assign out_if.valid = (cnt_ff != '0);
	assign out_if.data = store_ff[rd_ptr_ff];
	assign push = in_if.valid & in_if.ready;
	assign pop = out_if.valid & out_if.ready;

	always_comb
	begin
		nxt_wr_ptr = push ? wr_ptr_ff + PTR_ONE : wr_ptr_ff;
		nxt_rd_ptr = pop ? rd_ptr_ff + PTR_ONE : rd_ptr_ff;
		nxt_cnt = cnt_ff;
		if (push & ~pop)
			nxt_cnt = cnt_ff + CNT_ONE_P;
		else if (pop & ~push)
			nxt_cnt = cnt_ff - CNT_ONE_P;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
		end
		else
		begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			cnt_ff <= nxt_cnt;
		end
	end

	// storage needs no reset; empty flag guards it
	always_ff @(posedge clk_i)
	begin
		if (push)
			store_ff[wr_ptr_ff] <= in_if.data;
	end
endmodule : imb_fifo

// *** core/imb_core.sv ***
`timescale 1ns/1ns
// What this block does
// - 8K byte array behind serial bus
// - two address bytes, low 13 bits used
// - answer only when select bits match pins
// - data line driven open-drain only
// - sample on SCL rise, change on fall
// - protect pin high blocks all writes
// - protect pin low permits all writes
// - commit each byte once received
// - no busy state after writes
// - works with SCL up to 1 MHz
// - address increments, wraps 1FFF to 0000
// - write after 8th bit, before acknowledge
// - read continues MSB first while acknowledged
// - STOP aborts, ready for new transaction
module imb_core
	import imb_pkg::*;
(
	input wire logic MCLK_I,
	input wire logic RESET_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	input wire logic [2:0] CHIP_SEL_I,
	input wire logic WP_I
);
	logic [BYTE_W-1:0] mem_ff [0:MEM_DEPTH-1];

	logic [SYNC_STAGES-1:0] scl_sync_ff, sda_sync_ff;
	logic [SYNC_STAGES-1:0] nxt_scl_sync, nxt_sda_sync;
	logic scl_prev_ff, sda_prev_ff, nxt_scl_prev, nxt_sda_prev;
	logic scl, sda, scl_rise, scl_fall, start_det, stop_det;

	imb_state_t state_ff, nxt_state, ret_ff, nxt_ret;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [BYTE_W-1:0] sh_ff, nxt_sh, rx_byte, rd_byte;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [HI_ADDR_W-1:0] ahi_ff, nxt_ahi;
	logic oe_ff, nxt_oe;
	logic pend_ff, nxt_pend;
	logic [WORD_W-1:0] wword_ff, nxt_wword;
	logic load;
	logic sel_match;

	imb_word_if #(.W(WORD_W)) fill_if ();
	imb_word_if #(.W(WORD_W)) drain_if ();

	imb_fifo #(
		.W(WORD_W),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk_i(MCLK_I),
		.rst_i(RESET_I),
		.in_if(fill_if.snk),
		.out_if(drain_if.src)
	);

	always_comb
	begin
		nxt_scl_sync = {scl_sync_ff[0], SCL_I};
		nxt_sda_sync = {sda_sync_ff[0], SDA_I};
		nxt_scl_prev = scl_sync_ff[SYNC_STAGES-1];
		nxt_sda_prev = sda_sync_ff[SYNC_STAGES-1];
	end

	// idle bus is high, so reset to high avoids a false start
	always_ff @(posedge MCLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			scl_sync_ff <= '1;
			sda_sync_ff <= '1;
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end
		else
		begin
			scl_sync_ff <= nxt_scl_sync;
			sda_sync_ff <= nxt_sda_sync;
			scl_prev_ff <= nxt_scl_prev;
			sda_prev_ff <= nxt_sda_prev;
		end
	end

	// 125 MHz gives 125 samples per 1 MHz bit
	assign scl = scl_sync_ff[SYNC_STAGES-1];
	assign sda = sda_sync_ff[SYNC_STAGES-1];
	assign scl_rise = scl & ~scl_prev_ff;
	assign scl_fall = ~scl & scl_prev_ff;
	assign start_det = scl & scl_prev_ff & sda_prev_ff & ~sda;
	assign stop_det = scl & scl_prev_ff & ~sda_prev_ff & sda;

	assign rx_byte = {sh_ff[BYTE_W-2:0], sda};
	assign rd_byte = mem_ff[addr_ff];

	// type nibble and select bits must both match
	assign sel_match = (sh_ff[TA_TYPE_HI:TA_TYPE_LO] == DEV_TYPE) &&
		(sh_ff[TA_SEL_HI:TA_SEL_LO] == CHIP_SEL_I);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_ret = ret_ff;
		nxt_cnt = cnt_ff;
		nxt_sh = sh_ff;
		nxt_addr = addr_ff;
		nxt_ahi = ahi_ff;
		nxt_oe = oe_ff;
		nxt_wword = wword_ff;
		load = 1'b0;
		// a word waiting for the fifo leaves once accepted
		nxt_pend = pend_ff & ~fill_if.ready;
		if (stop_det)
		begin
			nxt_state = ST_IDLE;
			nxt_oe = 1'b0;
		end
		else if (start_det)
		begin
			nxt_state = ST_DEV;
			nxt_cnt = CNT_ZERO;
			nxt_oe = 1'b0;
		end
		else
		begin
			case (state_ff)
				ST_IDLE:
				begin
					nxt_oe = 1'b0;
				end
				ST_DEV, ST_ADH, ST_ADL, ST_WR:
				begin
					// incoming bits taken on the rising edge
					if (scl_rise && cnt_ff != BITS_PER_BYTE)
					begin
						nxt_sh = rx_byte;
						nxt_cnt = cnt_ff + CNT_ONE;
						// commit right after the 8th data bit
						if (state_ff == ST_WR &&
							cnt_ff == BITS_PER_BYTE - CNT_ONE)
						begin
							if (!WP_I)
							begin
								nxt_pend = 1'b1;
								nxt_wword = {addr_ff, rx_byte};
							end
							// advance and wrap after each byte
							nxt_addr = addr_ff + ADDR_ONE;
						end
					end
					else if (scl_fall && cnt_ff == BITS_PER_BYTE)
					begin
						nxt_cnt = CNT_ZERO;
						nxt_oe = 1'b1;
						nxt_state = ST_ACK;
						case (state_ff)
							ST_DEV:
							begin
								if (!sel_match)
								begin
									nxt_oe = 1'b0;
									nxt_state = ST_IDLE;
								end
								else if (sh_ff[TA_RW])
									nxt_ret = ST_RD;
								else
									nxt_ret = ST_ADH;
							end
							ST_ADH:
							begin
								nxt_ahi = sh_ff[HI_ADDR_W-1:0];
								nxt_ret = ST_ADL;
							end
							ST_ADL:
							begin
								nxt_addr = {ahi_ff, sh_ff};
								nxt_ret = ST_WR;
							end
							default:
							begin
								nxt_ret = ST_WR;
							end
						endcase
					end
				end
				ST_ACK:
				begin
					if (scl_fall)
					begin
						nxt_oe = 1'b0;
						nxt_cnt = CNT_ZERO;
						if (ret_ff == ST_RD)
							load = 1'b1;
						else
							nxt_state = ret_ff;
					end
				end
				ST_RD:
				begin
					if (scl_rise)
						nxt_cnt = cnt_ff + CNT_ONE;
					else if (scl_fall)
					begin
						if (cnt_ff == BITS_PER_BYTE)
						begin
							nxt_oe = 1'b0;
							nxt_state = ST_RACK;
						end
						else
						begin
							// outgoing bits change on the falling edge
							nxt_sh = {sh_ff[BYTE_W-2:0], 1'b0};
							nxt_oe = ~sh_ff[BYTE_W-2];
						end
					end
				end
				ST_RACK:
				begin
					// a missing acknowledge ends the read
					if (scl_rise)
						nxt_state = sda ? ST_IDLE : ST_RLD;
				end
				ST_RLD:
				begin
					if (scl_fall)
						load = 1'b1;
				end
				default:
				begin
					nxt_state = ST_IDLE;
					nxt_oe = 1'b0;
				end
			endcase
		end
		// next byte goes out MSB first
		if (load)
		begin
			nxt_sh = rd_byte;
			nxt_oe = ~rd_byte[BYTE_W-1];
			nxt_cnt = CNT_ZERO;
			nxt_addr = addr_ff + ADDR_ONE;
			nxt_state = ST_RD;
		end
	end

	always_ff @(posedge MCLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			state_ff <= ST_IDLE;
			ret_ff <= ST_IDLE;
			cnt_ff <= CNT_ZERO;
			sh_ff <= '0;
			addr_ff <= ADDR_RESET;
			ahi_ff <= '0;
			oe_ff <= 1'b0;
			pend_ff <= 1'b0;
			wword_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			ret_ff <= nxt_ret;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			addr_ff <= nxt_addr;
			ahi_ff <= nxt_ahi;
			oe_ff <= nxt_oe;
			pend_ff <= nxt_pend;
			wword_ff <= nxt_wword;
		end
	end

	assign fill_if.valid = pend_ff;
	assign fill_if.data = wword_ff;
	// array has one port: a read load stalls the drain for a cycle
	assign drain_if.ready = ~load;

	// the fifo drains within cycles, far inside one bit time
	always_ff @(posedge MCLK_I)
	begin
		if (drain_if.valid & drain_if.ready)
			mem_ff[drain_if.data[WORD_W-1:BYTE_W]] <=
				drain_if.data[BYTE_W-1:0];
	end

	// line only ever pulled low or released
	assign SDA_O = 1'b0;
	assign SDA_OE_O = oe_ff;
endmodule : imb_core

// *** verif/imb_core_monitor.sv ***
`timescale 1ns/1ns
module imb_core_monitor
(
	input wire logic MCLK_I,
	input wire logic RESET_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	input wire logic SDA_O,
	input wire logic SDA_OE_O
);
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (RESET_I);
	chk_od_value: assert property (SDA_O == 1'b0)
		else $error("sda not low");
	chk_edge_low: assert property ($changed(SDA_OE_O) |-> !SCL_I)
		else $error("moved in high");
	chk_fall_lag: assert property ($changed(SDA_OE_O) |->
		!$past(SCL_I, 3) && $past(SCL_I, 8)) else $error("bad lag");
	chk_hold_min: assert property ($rose(SDA_OE_O) |=> SDA_OE_O[*8])
		else $error("pull short");
	chk_free_bus: assert property (SDA_OE_O |-> ##[1:1000] !SDA_OE_O)
		else $error("pull long");
	chk_stop_free: assert property ($rose(SDA_I) && SCL_I |->
		##[0:8] !SDA_OE_O) else $error("held at stop");
	chk_start_free: assert property ($fell(SDA_I) && SCL_I |->
		##[0:8] !SDA_OE_O) else $error("held at start");
	chk_rst_quiet: assert property ($fell(RESET_I) |-> (!SDA_OE_O)[*4])
		else $error("pull at reset");
endmodule : imb_core_monitor
bind imb_core imb_core_monitor i_mon (.MCLK_I(MCLK_I), .RESET_I(RESET_I),
	.SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O));

// *** verif/imb_ctl_model.sv ***
`timescale 1ns/1ns
module imb_ctl_model
(
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o = 1'b1,
	output logic sda_o = 1'b1
);
	// phase far above the device's sync lag
	localparam int Q = 25;
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : wt
	// data moves only while clock is low
	task automatic bit_x(input logic b, output logic s);
		wt(4);
		sda_o = b;
		wt(Q);
		scl_o = 1'b1;
		wt(Q);
		s = sda_i;
		scl_o = 1'b0;
	endtask : bit_x
	// fin low gives start, high gives stop
	task automatic cond(input logic fin);
		wt(4);
		sda_o = ~fin;
		wt(4);
		scl_o = 1'b1;
		wt(Q);
		sda_o = fin;
		wt(Q);
		scl_o = fin;
	endtask : cond
	task automatic byte_x(input logic [7:0] d, input logic nak,
		output logic [7:0] q, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		bit_x(nak, s);
		ack = ~s;
	endtask : byte_x
endmodule : imb_ctl_model

// *** verif/imb_core_test.sv ***
`timescale 1ns/1ns
module imb_core_test
	import imb_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wp = 1'b0;
	logic [2:0] sel = 3'h0;
	logic scl, ctl_sda, oe, sda_v;
	wire sda_w;
	int err_total = 0;
	int check_count = 0;
	assign sda_w = ctl_sda & (~oe | sda_v);
	imb_core i_dut (.MCLK_I(clk), .RESET_I(rst), .SCL_I(scl),
		.SDA_I(sda_w), .SDA_O(sda_v), .SDA_OE_O(oe), .CHIP_SEL_I(sel),
		.WP_I(wp));
	imb_ctl_model i_ctl (.clk_i(clk), .sda_i(sda_w), .scl_o(scl),
		.sda_o(ctl_sda));
	task automatic chk(input string nm, input logic [7:0] s, e);
		check_count++;
		if (s !== e)
		begin
			err_total++;
			$display("ERROR %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic head(input logic [2:0] c, input logic rw, ex);
		logic [7:0] q;
		logic a;
		i_ctl.cond(1'b0);
		i_ctl.byte_x({DEV_TYPE, c, rw}, 1'b1, q, a);
		chk("dev ack", 8'(a), 8'(ex));
	endtask : head
	task automatic wd(input logic [7:0] d);
		logic [7:0] q;
		logic a;
		i_ctl.byte_x(d, 1'b1, q, a);
		chk("wr ack", 8'(a), 8'h01);
	endtask : wd
	task automatic seek(input logic [15:0] ad);
		head(sel, 1'b0, 1'b1);
		wd(ad[15:8]);
		wd(ad[7:0]);
	endtask : seek
	task automatic rsel(input logic [15:0] ad);
		seek(ad);
		head(sel, 1'b1, 1'b1);
	endtask : rsel
	task automatic rn(input logic [7:0] e, input logic more);
		logic [7:0] q;
		logic a;
		i_ctl.byte_x(8'hFF, ~more, q, a);
		chk("rd data", q, e);
	endtask : rn
	task automatic t_sel();
		logic [7:0] q;
		logic a;
		for (int k = 0; k < 8; k++)
		begin
			sel = k[2:0];
			head(sel, 1'b0, 1'b1);
			head(sel ^ 3'h1, 1'b0, 1'b0);
		end
		// wrong device type with matching select bits
		i_ctl.cond(1'b0);
		i_ctl.byte_x({DEV_TYPE ^ 4'h1, sel, 1'b0}, 1'b1, q, a);
		chk("type ack", 8'(a), 8'h00);
		i_ctl.cond(1'b1);
		$display("t_sel done");
	endtask : t_sel
	task automatic t_wrap();
		seek(16'hFFFF);
		wd(8'hA5);
		wd(8'h3C);
		i_ctl.cond(1'b1);
		rsel(16'h1FFF);
		rn(8'hA5, 1'b1);
		rn(8'h3C, 1'b0);
		$display("t_wrap done");
	endtask : t_wrap
	task automatic t_wp();
		wp = 1'b1;
		seek(16'h0000);
		wd(8'h00);
		wp = 1'b0;
		rsel(16'h0000);
		rn(8'h3C, 1'b0);
		$display("t_wp done");
	endtask : t_wp
	task automatic t_abort();
		logic s;
		seek(16'h0123);
		wd(8'h11);
		wd(8'h22);
		seek(16'h0124);
		repeat (4) i_ctl.bit_x(1'b0, s);
		i_ctl.cond(1'b1);
		rsel(16'h0123);
		rn(8'h11, 1'b1);
		rn(8'h22, 1'b0);
		i_ctl.cond(1'b1);
		$display("t_abort done");
	endtask : t_abort
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	initial
		forever
			#4 clk = ~clk;
	initial
	begin
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		t_sel();
		t_wrap();
		t_wp();
		t_abort();
		end_of_test();
	end
	initial
	begin
		#500000;
		err_total++;
		end_of_test();
	end
endmodule : imb_core_test
